/* include/hpp_pkg.sv */
// Shared constants and types of the parallel programming port sequencer
package hpp_pkg;

  // Command byte codes
  localparam logic [7:0] CMD_NOP       = 8'h00;
  localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_WR_FUSE   = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK   = 8'h20;
  localparam logic [7:0] CMD_RD_SIG    = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE   = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH  = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

  // Action selector codes {hi, lo}
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  // Byte selector codes {half, group}
  localparam logic [1:0] SEL_LOW  = 2'h0;
  localparam logic [1:0] SEL_EXT  = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;

  localparam logic [7:0] BYTE_ERASED   = 8'hFF;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [7:0] SIG_ADDR_LAST = 8'h02;
  localparam logic [7:0] CAL_ADDR      = 8'h00;

  // Lock byte: protection mode in bits 1:0, boot lock bits above
  localparam logic [1:0] LOCK_MODE3     = 2'h0;
  localparam logic [7:0] BOOT_LOCK_MASK = 8'h3C;

  // Fuse and lock write time
  localparam int CLK_PERIOD_NS = 25;
  localparam int FUSE_WAIT_NS  = 4500000;
  localparam int FUSE_WAIT_CYC = (FUSE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bit positions in the synchronised pin vector
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_DATA_MSB = 7;
  localparam int PIN_GROUP    = 8;
  localparam int PIN_HALF     = 9;
  localparam int PIN_ACT_LO   = 10;
  localparam int PIN_ACT_HI   = 11;
  localparam int PIN_LATCH    = 12;
  localparam int PIN_OE_N     = 13;
  localparam int PIN_WR_N     = 14;
  localparam int PIN_STROBE   = 15;
  localparam int PIN_W        = 16;
  localparam logic [PIN_W-1:0] PIN_RST = 16'h6000;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_MEM_BUSY  = 2'b01,
    ST_FUSE_BUSY = 2'b10
  } hpp_state_type;

endpackage : hpp_pkg

/* design/hpp_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module hpp_pin_sync #(
  parameter int         W       = 16,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } hpp_sync_type;

  hpp_sync_type r;
  hpp_sync_type next_r;

  // First stage feeds the second only; level moves when stages two and three agree
  always_comb
  begin
    next_r    = r;
    next_r.s1 = i_pin;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q  = (r.q & (r.s2 ^ r.s3)) | (r.s3 & ~(r.s2 ^ r.s3));
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    else
      r <= next_r;
  end

  assign o_level = r.q;

endmodule : hpp_pin_sync

/* design/hpp_prog_port.sv */
// Command, address and data sequencer of the high-voltage parallel programming port
`timescale 1ns/1ps
module hpp_prog_port #(
  parameter int                PAGE_WORDS    = 64,
  parameter int                FUSE_WAIT_CYC = hpp_pkg::FUSE_WAIT_CYC,
  parameter logic [7:0]        FUSE_LO_RST   = 8'hFF,
  parameter logic [7:0]        FUSE_HI_RST   = 8'hFF,
  parameter logic [7:0]        FUSE_EXT_RST  = 8'hFF,
  // Identification bytes, values arbitrary
  parameter logic [2:0][7:0]   SIG_BYTES     = 24'h5A_C3_A5
) (
  input  wire logic                      I_CLK_SYS,
  input  wire logic                      I_RST_N,
  input  wire logic                      I_PROG_MODE,
  input  wire logic                      I_ACTION_STROBE,
  input  wire logic                      I_ACTION_SELECT_HI,
  input  wire logic                      I_ACTION_SELECT_LO,
  input  wire logic                      I_BYTE_HALF_SELECT,
  input  wire logic                      I_BYTE_GROUP_SELECT,
  input  wire logic                      I_PAGE_BUFFER_LATCH,
  input  wire logic                      I_WR_N,
  input  wire logic                      I_OE_N,
  input  wire logic [7:0]                I_DATA,
  output logic      [7:0]                O_DATA,
  output logic                           O_DATA_OE_N,
  output logic                           O_OPERATION_DONE_FLAG,
  input  wire logic                      I_FULL_ERASE,
  input  wire logic [7:0]                I_CALIB,
  output logic                           O_PGM_START,
  output logic                           O_PGM_EEPROM,
  output logic [15-$clog2(PAGE_WORDS):0] O_PAGE_NUM,
  input  wire logic                      I_PGM_DONE,
  input  wire logic [$clog2(PAGE_WORDS)-1:0] I_BUF_IDX,
  output logic      [15:0]               O_BUF_WORD,
  output logic      [15:0]               O_RD_ADDR,
  input  wire logic [15:0]               I_FLASH_WORD,
  input  wire logic [7:0]                I_EE_BYTE,
  output logic      [7:0]                O_FUSE_LO,
  output logic      [7:0]                O_FUSE_HI,
  output logic      [7:0]                O_FUSE_EXT,
  output logic      [7:0]                O_LOCK
);

  localparam int WORD_BITS = $clog2(PAGE_WORDS);
  localparam int CNT_W     = $clog2(FUSE_WAIT_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FUSE_WAIT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  typedef struct packed {
    hpp_pkg::hpp_state_type          state;
    logic                            prev_strobe;
    logic                            prev_wr_n;
    logic                            prev_latch;
    logic [7:0]                      cmd;
    logic [7:0]                      addr_lo;
    logic [7:0]                      addr_hi;
    logic [7:0]                      data_lo;
    logic [7:0]                      data_hi;
    logic                            armed;
    logic                            pgm_start;
    logic                            pgm_eeprom;
    logic [CNT_W-1:0]                cnt;
    logic [7:0]                      fuse_lo;
    logic [7:0]                      fuse_hi;
    logic [7:0]                      fuse_ext;
    logic [7:0]                      lock;
    logic [7:0]                      dout;
    logic                            drive;
    logic [15:0]                     buf_word;
    logic [PAGE_WORDS-1:0][15:0]     page;
  } hpp_regs_type;

  localparam hpp_regs_type REG_RST = '{
    state:       hpp_pkg::ST_IDLE,
    prev_wr_n:   1'b1,
    fuse_lo:     FUSE_LO_RST,
    fuse_hi:     FUSE_HI_RST,
    fuse_ext:    FUSE_EXT_RST,
    lock:        hpp_pkg::BYTE_ERASED,
    dout:        hpp_pkg::BYTE_ERASED,
    default:     '0
  };

  hpp_regs_type r;
  hpp_regs_type next_r;

  logic [hpp_pkg::PIN_W-1:0] pins;
  logic [7:0]                pin_data;
  logic [1:0]                act;
  logic [1:0]                sel;
  logic                      half;
  logic                      strobe_rise;
  logic                      wr_fall;
  logic                      latch_rise;
  logic                      is_write_cmd;
  logic                      is_read_cmd;
  logic [WORD_BITS-1:0]      word_idx;
  logic [7:0]                rd_byte;
  logic [7:0]                lock_keep;

  hpp_pin_sync #(
    .W       (hpp_pkg::PIN_W),
    .RST_VAL (hpp_pkg::PIN_RST)
  ) u_pin_sync (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_pin   ({I_ACTION_STROBE, I_WR_N, I_OE_N, I_PAGE_BUFFER_LATCH, I_ACTION_SELECT_HI,
               I_ACTION_SELECT_LO, I_BYTE_HALF_SELECT, I_BYTE_GROUP_SELECT, I_DATA}),
    .o_level (pins)
  );

  assign pin_data    = pins[hpp_pkg::PIN_DATA_MSB:hpp_pkg::PIN_DATA_LSB];
  assign act         = {pins[hpp_pkg::PIN_ACT_HI], pins[hpp_pkg::PIN_ACT_LO]};
  assign half        = pins[hpp_pkg::PIN_HALF];
  assign sel         = {half, pins[hpp_pkg::PIN_GROUP]};
  // Edges taken from the filtered level so each pulse acts once
  assign strobe_rise = pins[hpp_pkg::PIN_STROBE] & ~r.prev_strobe;
  assign wr_fall     = r.prev_wr_n & ~pins[hpp_pkg::PIN_WR_N];
  assign latch_rise  = pins[hpp_pkg::PIN_LATCH] & ~r.prev_latch;
  assign word_idx    = r.addr_lo[WORD_BITS-1:0];
  assign is_write_cmd = (pin_data == hpp_pkg::CMD_WR_FLASH) | (pin_data == hpp_pkg::CMD_WR_EEPROM)
                      | (pin_data == hpp_pkg::CMD_WR_FUSE) | (pin_data == hpp_pkg::CMD_WR_LOCK);
  assign is_read_cmd = (r.cmd == hpp_pkg::CMD_RD_FLASH) | (r.cmd == hpp_pkg::CMD_RD_EEPROM)
                     | (r.cmd == hpp_pkg::CMD_RD_FUSE) | (r.cmd == hpp_pkg::CMD_RD_SIG);
  // Mode 3 keeps boot lock bits out of reach of a lock write
  assign lock_keep   = (r.lock[1:0] == hpp_pkg::LOCK_MODE3) ? hpp_pkg::BOOT_LOCK_MASK
                                                            : hpp_pkg::BYTE_ZERO;

  // Read data selection
  always_comb
  begin
    rd_byte = hpp_pkg::BYTE_ERASED;
    case (r.cmd)
      hpp_pkg::CMD_RD_FLASH:
        rd_byte = half ? I_FLASH_WORD[15:8] : I_FLASH_WORD[7:0];
      hpp_pkg::CMD_RD_EEPROM:
        if (!half)
          rd_byte = I_EE_BYTE;
      hpp_pkg::CMD_RD_FUSE:
        case (sel)
          hpp_pkg::SEL_LOW:  rd_byte = r.fuse_lo;
          hpp_pkg::SEL_BOTH: rd_byte = r.fuse_hi;
          hpp_pkg::SEL_EXT:  rd_byte = r.fuse_ext;
          default:           rd_byte = r.lock;
        endcase
      hpp_pkg::CMD_RD_SIG:
        if (!half && r.addr_lo <= hpp_pkg::SIG_ADDR_LAST)
          rd_byte = SIG_BYTES[r.addr_lo[1:0]];
        else if (half && r.addr_lo == hpp_pkg::CAL_ADDR)
          rd_byte = I_CALIB;
      default:
        rd_byte = hpp_pkg::BYTE_ERASED;
    endcase
  end

  always_comb
  begin
    next_r             = r;
    next_r.pgm_start   = 1'b0;
    next_r.prev_strobe = pins[hpp_pkg::PIN_STROBE];
    next_r.prev_wr_n   = pins[hpp_pkg::PIN_WR_N];
    next_r.prev_latch  = pins[hpp_pkg::PIN_LATCH];
    next_r.buf_word    = r.page[I_BUF_IDX];
    next_r.dout        = rd_byte;
    next_r.drive       = I_PROG_MODE & ~pins[hpp_pkg::PIN_OE_N] & is_read_cmd;
    // Busy tracking runs even if the mode input drops mid-operation
    case (r.state)
      hpp_pkg::ST_MEM_BUSY:
        if (I_PGM_DONE)
          next_r.state = hpp_pkg::ST_IDLE;
      hpp_pkg::ST_FUSE_BUSY:
        if (r.cnt >= CNT_LAST)
          next_r.state = hpp_pkg::ST_IDLE;
        else
          next_r.cnt = r.cnt + CNT_ONE;
      default:
        next_r.state = hpp_pkg::ST_IDLE;
    endcase
    if (I_PROG_MODE)
    begin
      // Loaded command and address stay until overwritten
      if (strobe_rise)
      begin
        case (act)
          hpp_pkg::ACT_ADDR:
            if (half)
              next_r.addr_hi = pin_data;
            else
              next_r.addr_lo = pin_data;
          hpp_pkg::ACT_DATA:
            if (half)
              next_r.data_hi = pin_data;
            else
              next_r.data_lo = pin_data;
          hpp_pkg::ACT_CMD:
          begin
            next_r.cmd   = pin_data;
            next_r.armed = is_write_cmd;
          end
          default:
            next_r.cmd = r.cmd;
        endcase
      end
      // Buffer is not touched while the page is being written out
      if (latch_rise && r.state == hpp_pkg::ST_IDLE && r.armed)
      begin
        if (r.cmd == hpp_pkg::CMD_WR_FLASH && half)
          next_r.page[word_idx] = {r.data_hi, r.data_lo};
        else if (r.cmd == hpp_pkg::CMD_WR_EEPROM)
          next_r.page[word_idx] = {hpp_pkg::BYTE_ZERO, r.data_lo};
      end
      // Write pulses during busy are dropped
      if (wr_fall && r.state == hpp_pkg::ST_IDLE && r.armed)
      begin
        next_r.cnt = '0;
        case (r.cmd)
          hpp_pkg::CMD_WR_FLASH:
          begin
            next_r.pgm_start  = 1'b1;
            next_r.pgm_eeprom = 1'b0;
            next_r.state      = hpp_pkg::ST_MEM_BUSY;
          end
          hpp_pkg::CMD_WR_EEPROM:
            if (!half)
            begin
              next_r.pgm_start  = 1'b1;
              next_r.pgm_eeprom = 1'b1;
              next_r.state      = hpp_pkg::ST_MEM_BUSY;
            end
          hpp_pkg::CMD_WR_FUSE:
            case (sel)
              hpp_pkg::SEL_LOW:
              begin
                next_r.fuse_lo = r.data_lo;
                next_r.state   = hpp_pkg::ST_FUSE_BUSY;
              end
              hpp_pkg::SEL_HIGH:
              begin
                next_r.fuse_hi = r.data_lo;
                next_r.state   = hpp_pkg::ST_FUSE_BUSY;
              end
              hpp_pkg::SEL_EXT:
              begin
                next_r.fuse_ext = r.data_lo;
                next_r.state    = hpp_pkg::ST_FUSE_BUSY;
              end
              default:
                next_r.state = r.state;
            endcase
          hpp_pkg::CMD_WR_LOCK:
          begin
            // Only zeros are taken; a one never restores a bit
            next_r.lock  = r.lock & (r.data_lo | lock_keep);
            next_r.state = hpp_pkg::ST_FUSE_BUSY;
          end
          default:
            next_r.state = r.state;
        endcase
      end
    end
    if (I_FULL_ERASE)
      next_r.lock = hpp_pkg::BYTE_ERASED;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      r <= REG_RST;
    else
      r <= next_r;
  end

  assign O_DATA                = r.dout;
  assign O_DATA_OE_N           = ~r.drive;
  assign O_OPERATION_DONE_FLAG = (r.state == hpp_pkg::ST_IDLE);
  assign O_PGM_START           = r.pgm_start;
  assign O_PGM_EEPROM          = r.pgm_eeprom;
  assign O_PAGE_NUM            = {r.addr_hi, r.addr_lo[7:WORD_BITS]};
  assign O_BUF_WORD            = r.buf_word;
  assign O_RD_ADDR             = {r.addr_hi, r.addr_lo};
  assign O_FUSE_LO             = r.fuse_lo;
  assign O_FUSE_HI             = r.fuse_hi;
  assign O_FUSE_EXT            = r.fuse_ext;
  assign O_LOCK                = r.lock;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  sequence flash_wr_s;
    wr_fall && I_PROG_MODE && r.state == hpp_pkg::ST_IDLE && r.armed
      && r.cmd == hpp_pkg::CMD_WR_FLASH;
  endsequence

  sequence busy_hold_s;
    !O_OPERATION_DONE_FLAG && O_PGM_START ##1 !O_OPERATION_DONE_FLAG && !O_PGM_START;
  endsequence

  cmd_load_a: assert property (strobe_rise && I_PROG_MODE && act == hpp_pkg::ACT_CMD
    |=> r.cmd == $past(pin_data)) else $error("command not captured");
  addr_lo_load_a: assert property (strobe_rise && I_PROG_MODE && act == hpp_pkg::ACT_ADDR && !half
    |=> r.addr_lo == $past(pin_data) && $stable(r.addr_hi)) else $error("low address");
  addr_hi_load_a: assert property (strobe_rise && I_PROG_MODE && act == hpp_pkg::ACT_ADDR && half
    |=> r.addr_hi == $past(pin_data) && $stable(r.addr_lo)) else $error("high address");
  data_lo_load_a: assert property (strobe_rise && I_PROG_MODE && act == hpp_pkg::ACT_DATA && !half
    |=> r.data_lo == $past(pin_data)) else $error("low data");
  data_hi_load_a: assert property (strobe_rise && I_PROG_MODE && act == hpp_pkg::ACT_DATA && half
    |=> r.data_hi == $past(pin_data)) else $error("high data");
  idle_action_a: assert property (strobe_rise && act == hpp_pkg::ACT_IDLE
    |=> $stable(r.cmd) && $stable(r.addr_lo) && $stable(r.data_lo)) else $error("idle acted");
  page_latch_a: assert property (latch_rise && I_PROG_MODE && half && r.armed
    && r.state == hpp_pkg::ST_IDLE && r.cmd == hpp_pkg::CMD_WR_FLASH
    |=> r.page[$past(word_idx)] == {$past(r.data_hi), $past(r.data_lo)}) else $error("latch");
  flash_busy_a: assert property (flash_wr_s |=> busy_hold_s) else $error("no busy");
  nop_disarm_a: assert property (strobe_rise && I_PROG_MODE && act == hpp_pkg::ACT_CMD
    && pin_data == hpp_pkg::CMD_NOP |=> !r.armed ##1 !O_PGM_START) else $error("nop");
  busy_ignore_a: assert property (wr_fall && r.state != hpp_pkg::ST_IDLE
    |=> !O_PGM_START) else $error("write taken while busy");
  lock_mono_a: assert property (!$past(I_FULL_ERASE)
    |-> (r.lock & ~$past(r.lock)) == hpp_pkg::BYTE_ZERO) else $error("lock bit restored");
  boot_guard_a: assert property (r.lock[1:0] == hpp_pkg::LOCK_MODE3 && !I_FULL_ERASE
    |=> (r.lock & hpp_pkg::BOOT_LOCK_MASK) == ($past(r.lock) & hpp_pkg::BOOT_LOCK_MASK))
    else $error("boot lock changed");
  flash_read_a: assert property (I_PROG_MODE && !pins[hpp_pkg::PIN_OE_N]
    && r.cmd == hpp_pkg::CMD_RD_FLASH ##1 1'b1 |-> !O_DATA_OE_N
    && O_DATA == ($past(half) ? $past(I_FLASH_WORD[15:8]) : $past(I_FLASH_WORD[7:0])))
    else $error("flash read");
  fuse_done_a: assert property (r.state == hpp_pkg::ST_FUSE_BUSY && r.cnt >= CNT_LAST
    |=> O_OPERATION_DONE_FLAG) else $error("fuse wait");

endmodule : hpp_prog_port

/* verif/hpp_backend_model.sv */
// Memory backend model: completes page writes and supplies read data
`timescale 1ns/1ps
module hpp_backend_model #(
  parameter int DELAY = 40
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic [15:0] i_rd_addr,
  output logic             o_done,
  output logic      [15:0] o_flash_word,
  output logic      [7:0]  o_ee_byte
);
  int cnt;

  // Slow answer so that a second write pulse lands while busy
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt    <= 0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= (cnt == 1);
      if (i_start)
        cnt <= DELAY;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end

  assign o_flash_word = ~i_rd_addr ^ 16'hA55A;
  assign o_ee_byte    = i_rd_addr[7:0] ^ 8'h3C;
endmodule : hpp_backend_model

/* verif/hpp_prog_port_bench.sv */
// Self-checking bench of the parallel programming port sequencer
`timescale 1ns/1ps
module hpp_prog_port_bench;
  // Identification bytes, values arbitrary
  localparam logic [2:0][7:0] SIG = 24'h1E_96_4B;
  logic       clk, rst_n, stb, ahi, alo, half, grp, lat, wr_n, oe_n, ers, pdone, oe_o, st, eep;
  logic       rdy, pm;
  logic [7:0] din, cal, eeb, dout, flo, fhi, fext, lck, a_lo, a_hi, d_lo, d_hi;
  logic [9:0] page;
  logic [5:0] idx;
  logic [15:0] bword, raddr, fword;
  logic [2:0][7:0] fx;
  int         n_mismatch, check_count, n_start, s;

  hpp_prog_port #(.FUSE_WAIT_CYC(8), .SIG_BYTES(SIG)) u_hpp_prog_port (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PROG_MODE(pm), .I_ACTION_STROBE(stb),
    .I_ACTION_SELECT_HI(ahi), .I_ACTION_SELECT_LO(alo), .I_BYTE_HALF_SELECT(half),
    .I_BYTE_GROUP_SELECT(grp), .I_PAGE_BUFFER_LATCH(lat), .I_WR_N(wr_n), .I_OE_N(oe_n),
    .I_DATA(din), .O_DATA(dout), .O_DATA_OE_N(oe_o), .O_OPERATION_DONE_FLAG(rdy),
    .I_FULL_ERASE(ers), .I_CALIB(cal), .O_PGM_START(st), .O_PGM_EEPROM(eep),
    .O_PAGE_NUM(page), .I_PGM_DONE(pdone), .I_BUF_IDX(idx), .O_BUF_WORD(bword),
    .O_RD_ADDR(raddr), .I_FLASH_WORD(fword), .I_EE_BYTE(eeb), .O_FUSE_LO(flo),
    .O_FUSE_HI(fhi), .O_FUSE_EXT(fext), .O_LOCK(lck));
  hpp_backend_model u_hpp_backend_model (.i_clk(clk), .i_rst_n(rst_n), .i_start(st),
    .i_rd_addr(raddr), .o_done(pdone), .o_flash_word(fword), .o_ee_byte(eeb));

  initial begin clk = 1'b0; forever #12.5 clk = ~clk; end
  always @(posedge clk) if (st === 1'b1) n_start++;

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Byte the backend model shows for a flash word read
  function automatic logic [7:0] flash_byte(input logic h, input logic [15:0] a);
    logic [15:0] wd;
    wd = ~a ^ 16'hA55A;
    return h ? wd[15:8] : wd[7:0];
  endfunction : flash_byte
  task automatic w(input int n); repeat (n) @(posedge clk); endtask : w
  task automatic load(input logic [1:0] act, input logic h, input logic [7:0] d);
    {ahi, alo} <= act; half <= h; din <= d;
    w(6); stb <= 1'b1; w(6); stb <= 1'b0; w(6);
  endtask : load
  task automatic latch(); lat <= 1'b1; w(6); lat <= 1'b0; w(6); endtask : latch
  task automatic write(input logic armed, input int pulses);
    repeat (pulses)
    begin
      wr_n <= 1'b0; w(6); chk(rdy, !armed); wr_n <= 1'b1; w(6);
    end
    for (int k = 0; k < 400 && rdy !== 1'b1; k++) w(1);
    w(2); chk(rdy, 1'b1);
  endtask : write
  task automatic rd(input logic h, input logic g, input logic [7:0] exp);
    half <= h; grp <= g; oe_n <= 1'b0; w(8);
    chk(oe_o, 1'b0); chk(dout, exp); oe_n <= 1'b1; w(6); chk(oe_o, 1'b1);
  endtask : rd

  initial begin
    {rst_n, stb, ahi, alo, half, grp, lat, ers, din, idx} = '0;
    {wr_n, oe_n} = 2'b11;
    pm = 1'b1;
    void'($urandom(32'h5bffe209));
    cal = $urandom; w(16); rst_n <= 1'b1; w(8);
    chk(rdy, 1); chk(oe_o, 1); chk({flo, fhi}, 16'hFFFF); chk({fext, lck}, 16'hFFFF);
    a_hi = $urandom;
    load(hpp_pkg::ACT_CMD, 0, hpp_pkg::CMD_WR_FLASH);
    load(hpp_pkg::ACT_ADDR, 1, a_hi);
    for (int i = 0; i < 3; i++)
    begin
      a_lo = $urandom; d_lo = $urandom; d_hi = $urandom;
      load(hpp_pkg::ACT_ADDR, 0, a_lo);
      load(hpp_pkg::ACT_DATA, 0, d_lo);
      load(hpp_pkg::ACT_DATA, 1, d_hi);
      latch(); s = n_start; write(1, 2); chk(n_start - s, 1);
      chk(page, {a_hi, a_lo[7:6]}); chk(eep, 0);
      idx <= a_lo[5:0]; w(3); chk(bword, {d_hi, d_lo});
    end
    load(hpp_pkg::ACT_CMD, 0, hpp_pkg::CMD_NOP);
    s = n_start; write(0, 1); chk(n_start - s, 0);
    a_lo = $urandom; d_lo = $urandom;
    load(hpp_pkg::ACT_CMD, 0, hpp_pkg::CMD_WR_EEPROM);
    load(hpp_pkg::ACT_ADDR, 0, a_lo);
    load(hpp_pkg::ACT_DATA, 0, d_lo);
    latch(); s = n_start; write(1, 1); chk(n_start - s, 1); chk(eep, 1);
    idx <= a_lo[5:0]; w(3); chk(bword, {8'h00, d_lo});
    load(hpp_pkg::ACT_CMD, 0, hpp_pkg::CMD_WR_FUSE);
    for (int i = 0; i < 3; i++)
    begin
      fx[i] = $urandom;
      load(hpp_pkg::ACT_DATA, 0, fx[i]);
      {half, grp} <= (i == 0) ? 2'h0 : (i == 1) ? 2'h2 : 2'h1; w(6);
      write(1, 1); {half, grp} <= 2'h0; w(2);
    end
    chk({flo, fhi}, {fx[0], fx[1]}); chk(fext, fx[2]);
    load(hpp_pkg::ACT_CMD, 0, hpp_pkg::CMD_WR_LOCK);
    load(hpp_pkg::ACT_DATA, 0, 8'hFC); write(1, 1); chk(lck, 8'hFC);
    load(hpp_pkg::ACT_DATA, 0, 8'h00); write(1, 1); chk(lck, 8'h3C);
    load(hpp_pkg::ACT_DATA, 0, 8'hFF); write(1, 1); chk(lck, 8'h3C);
    ers <= 1'b1; w(2); ers <= 1'b0; w(2); chk(lck, 8'hFF);
    a_lo = $urandom; a_hi = $urandom;
    load(hpp_pkg::ACT_CMD, 0, hpp_pkg::CMD_RD_FLASH);
    load(hpp_pkg::ACT_ADDR, 1, a_hi);
    load(hpp_pkg::ACT_ADDR, 0, a_lo);
    rd(0, 0, flash_byte(0, {a_hi, a_lo})); rd(1, 0, flash_byte(1, {a_hi, a_lo}));
    load(hpp_pkg::ACT_CMD, 0, hpp_pkg::CMD_RD_EEPROM);
    rd(0, 0, a_lo ^ 8'h3C);
    load(hpp_pkg::ACT_CMD, 0, hpp_pkg::CMD_RD_FUSE);
    rd(0, 0, fx[0]); rd(1, 1, fx[1]); rd(0, 1, fx[2]); rd(1, 0, 8'hFF);
    // Outside programming mode the bus must stay released
    pm <= 1'b0; oe_n <= 1'b0; w(8); chk(oe_o, 1'b1);
    oe_n <= 1'b1; pm <= 1'b1; w(2);
    load(hpp_pkg::ACT_CMD, 0, hpp_pkg::CMD_RD_SIG);
    for (int a = 0; a < 3; a++)
    begin
      load(hpp_pkg::ACT_ADDR, 0, 8'(a));
      load(hpp_pkg::ACT_IDLE, 0, 8'h00); rd(0, 0, SIG[a]);
    end
    load(hpp_pkg::ACT_ADDR, 0, 8'h00);
    rd(1, 0, cal);
    results();
  end

  initial begin
    #(25 * 60000);
    n_mismatch++;
    results();
  end
endmodule : hpp_prog_port_bench
